// [rtl/lpm_top.sv]
// Low-power mode control and bus clock gating with an APB register slave
//
// What this block does
// - Wait mode stops processor clocks, peripherals run
// - Reset, or break in emulation, leaves wait
// - Break during wait sets break flag
// - Watchdog disable bit clear keeps watchdog running
// - Stop entry clears counter, disables system clocks
// - Any peripheral interrupt request exits stop
// - Interrupt stacking waits for stop recovery end
// - Reset or break also ends stop
// - Stop gates double and quadruple bus clocks
// - Keep-oscillator option leaves double-rate clock running
// - Recovery 4096 cycles, or 32 when short
// - Frequency select field sets internal oscillator speed
// - Crystal range field picks low, medium, high
// - Clock source switches any time without reset
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps

`include "lpm_params.svh"

module lpm_top
  import lpm_pkg::*;
#(
  parameter logic [12:0] REC_LONG = 13'(`LPM_STOP_REC_LONG),
  parameter logic [12:0] REC_SHORT = 13'(`LPM_STOP_REC_SHORT)
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic irq_req,
  input wire logic break_req,
  input wire logic emul_mode,
  input wire logic ext_clock_gate_pin,
  output logic cpu_clk_en,
  output logic bus_clock_double_rate_en,
  output logic bus_clock_quad_rate_en,
  output logic watchdog_en,
  output logic irq_stack_ok,
  output logic [1:0] osc_source_option,
  output logic [1:0] internal_osc_freq_sel,
  output logic [1:0] external_crystal_range_sel,
  output logic external_clock_gate_on
);

  // ========================================================
  // State
  lpm_state_s state_reg;
  lpm_state_s state_next;

  logic bus_setup;
  logic bus_write;
  logic addr_hit;
  logic [7:0] rd_byte;
  logic [12:0] rec_limit;

  // ========================================================
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;

    // Pin from the oscillator domain, two flops before use
    state_next.gate_sync1 = ext_clock_gate_pin;
    state_next.gate_sync2 = state_reg.gate_sync1;
    state_next.osc_sc[`LPM_ECG_ST_BIT] = state_reg.gate_sync2;

    // ------------------------------------------------------
    // APB slave: one wait state, answer from flops
    bus_setup = psel && penable && !state_reg.rsp.pready;
    bus_write = psel && penable && state_reg.rsp.pready && pwrite
                && pstrb[0];
    addr_hit = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      `LPM_OSC_SC_OFS:
      begin
        rd_byte = state_reg.osc_sc;
      end
      `LPM_CFG_ONE_OFS:
      begin
        rd_byte = state_reg.cfg_one;
      end
      `LPM_BRK_STAT_OFS:
      begin
        rd_byte[`LPM_BREAK_STOP_WAIT_FLAG_BIT] = state_reg.break_stop_wait_flag;
      end
      `LPM_MODE_STAT_OFS:
      begin
        rd_byte = {5'h00, state_reg.clk.irq_stack_ok,
                   state_reg.mode};
      end
      default:
      begin
        addr_hit = 1'b0;
      end
    endcase

    state_next.rsp.pready = bus_setup;
    state_next.rsp.pslverr = bus_setup && !addr_hit;
    if (bus_setup && !pwrite && addr_hit)
    begin
      state_next.rsp.prdata = {24'h000000, rd_byte};
    end
    else if (bus_setup)
    begin
      state_next.rsp.prdata = 32'h00000000;
    end

    // ------------------------------------------------------
    // Register writes; oscillator choices take effect at
    // once, no reset needed to switch sources or speeds
    if (bus_write && paddr == `LPM_OSC_SC_OFS)
    begin
      state_next.osc_sc[`LPM_OSC_SOURCE_OPTION_HI:`LPM_OSC_SOURCE_OPTION_LO] =
        pwdata[`LPM_OSC_SOURCE_OPTION_HI:`LPM_OSC_SOURCE_OPTION_LO];
      state_next.osc_sc[`LPM_INTERNAL_OSC_FREQ_SEL_HI:`LPM_INTERNAL_OSC_FREQ_SEL_LO] =
        pwdata[`LPM_INTERNAL_OSC_FREQ_SEL_HI:`LPM_INTERNAL_OSC_FREQ_SEL_LO];
      state_next.osc_sc[`LPM_EXTERNAL_CRYSTAL_RANGE_SEL_HI:`LPM_EXTERNAL_CRYSTAL_RANGE_SEL_LO] =
        pwdata[`LPM_EXTERNAL_CRYSTAL_RANGE_SEL_HI:`LPM_EXTERNAL_CRYSTAL_RANGE_SEL_LO];
      state_next.osc_sc[`LPM_ECG_ON_BIT] =
        pwdata[`LPM_ECG_ON_BIT];
    end
    if (bus_write && paddr == `LPM_CFG_ONE_OFS)
    begin
      state_next.cfg_one = {5'h00, pwdata[2:0]};
    end
    // Write one to clear; a break in the same cycle wins
    if (bus_write && paddr == `LPM_BRK_STAT_OFS
        && pwdata[`LPM_BREAK_STOP_WAIT_FLAG_BIT])
    begin
      state_next.break_stop_wait_flag = 1'b0;
    end
    if (break_req && state_reg.mode == LPM_WAIT)
    begin
      state_next.break_stop_wait_flag = 1'b1;
    end

    // ------------------------------------------------------
    // Mode sequencing
    // Short recovery suits on-chip clocks only; a crystal
    // needs the long count to settle
    rec_limit = state_reg.cfg_one[`LPM_SHORT_STOP_RECOVERY_BIT] ?
                REC_SHORT : REC_LONG;
    unique case (state_reg.mode)
      LPM_RUN:
      begin
        if (stop_instr)
        begin
          state_next.mode = LPM_STOP;
          state_next.rec_cnt = 13'h0000;
        end
        else if (wait_instr)
        begin
          state_next.mode = LPM_WAIT;
        end
      end
      LPM_WAIT:
      begin
        if (irq_req || (break_req && emul_mode))
        begin
          state_next.mode = LPM_RUN;
        end
      end
      LPM_STOP:
      begin
        if (irq_req || break_req)
        begin
          state_next.mode = LPM_RECOVER;
          state_next.rec_cnt = 13'h0000;
        end
      end
      LPM_RECOVER:
      begin
        if (state_reg.rec_cnt == rec_limit - 13'h0001)
        begin
          state_next.mode = LPM_RUN;
        end
        else
        begin
          state_next.rec_cnt = state_reg.rec_cnt + 13'h0001;
        end
      end
    endcase

    // ------------------------------------------------------
    // Clock enables follow the coming mode
    state_next.clk.cpu_clk_en =
      (state_next.mode == LPM_RUN);
    // Bus clocks restart for recovery so the count can run
    state_next.clk.bus_clock_quad_rate_en =
      (state_next.mode != LPM_STOP);
    state_next.clk.bus_clock_double_rate_en =
      (state_next.mode != LPM_STOP)
      || state_reg.cfg_one[`LPM_KEEP_OSC_BIT];
    // Not gated by wait: the watchdog keeps counting there
    state_next.clk.watchdog_en =
      !state_reg.cfg_one[`LPM_WDOG_DIS_BIT];
    state_next.clk.irq_stack_ok =
      (state_next.mode != LPM_STOP)
      && (state_next.mode != LPM_RECOVER);
  end

  // ========================================================
  // Registers; reset also ends wait and stop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg.mode <= LPM_RUN;
      state_reg.rec_cnt <= 13'h0000;
      state_reg.osc_sc <= `LPM_OSC_SC_RESET;
      state_reg.cfg_one <= `LPM_CFG_ONE_RESET;
      state_reg.break_stop_wait_flag <= 1'b0;
      state_reg.gate_sync1 <= 1'b0;
      state_reg.gate_sync2 <= 1'b0;
      state_reg.clk.cpu_clk_en <= 1'b1;
      state_reg.clk.bus_clock_double_rate_en <= 1'b1;
      state_reg.clk.bus_clock_quad_rate_en <= 1'b1;
      state_reg.clk.watchdog_en <= 1'b1;
      state_reg.clk.irq_stack_ok <= 1'b1;
      state_reg.rsp.pready <= 1'b0;
      state_reg.rsp.pslverr <= 1'b0;
      state_reg.rsp.prdata <= 32'h00000000;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ========================================================
  // Outputs, all straight from flops
  assign pready = state_reg.rsp.pready;
  assign pslverr = state_reg.rsp.pslverr;
  assign prdata = state_reg.rsp.prdata;
  assign cpu_clk_en = state_reg.clk.cpu_clk_en;
  assign bus_clock_double_rate_en =
    state_reg.clk.bus_clock_double_rate_en;
  assign bus_clock_quad_rate_en =
    state_reg.clk.bus_clock_quad_rate_en;
  assign watchdog_en = state_reg.clk.watchdog_en;
  assign irq_stack_ok = state_reg.clk.irq_stack_ok;
  assign osc_source_option =
    state_reg.osc_sc[`LPM_OSC_SOURCE_OPTION_HI:`LPM_OSC_SOURCE_OPTION_LO];
  assign internal_osc_freq_sel =
    state_reg.osc_sc[`LPM_INTERNAL_OSC_FREQ_SEL_HI:`LPM_INTERNAL_OSC_FREQ_SEL_LO];
  assign external_crystal_range_sel =
    state_reg.osc_sc[`LPM_EXTERNAL_CRYSTAL_RANGE_SEL_HI:`LPM_EXTERNAL_CRYSTAL_RANGE_SEL_LO];
  assign external_clock_gate_on =
    state_reg.osc_sc[`LPM_ECG_ON_BIT];

endmodule // lpm_top

// [rtl/lpm_params.svh]
// Offsets, field positions, reset values and counts of the low-power block
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define LPM_OSC_SC_OFS 8'h00
`define LPM_CFG_ONE_OFS 8'h04
`define LPM_BRK_STAT_OFS 8'h08
`define LPM_MODE_STAT_OFS 8'h0C

// ==========================================================
// osc_status_control fields
`define LPM_OSC_SC_RESET 8'h20
`define LPM_OSC_SOURCE_OPTION_HI 7
`define LPM_OSC_SOURCE_OPTION_LO 6
`define LPM_INTERNAL_OSC_FREQ_SEL_HI 5
`define LPM_INTERNAL_OSC_FREQ_SEL_LO 4
`define LPM_EXTERNAL_CRYSTAL_RANGE_SEL_HI 3
`define LPM_EXTERNAL_CRYSTAL_RANGE_SEL_LO 2
`define LPM_ECG_ON_BIT 1
`define LPM_ECG_ST_BIT 0

// ==========================================================
// config_reg_one fields
`define LPM_CFG_ONE_RESET 8'h00
`define LPM_SHORT_STOP_RECOVERY_BIT 0
`define LPM_KEEP_OSC_BIT 1
`define LPM_WDOG_DIS_BIT 2

// ==========================================================
// break_status_reg fields
`define LPM_BREAK_STOP_WAIT_FLAG_BIT 1

// ==========================================================
// Stop recovery counts, in quadruple-rate bus clock cycles
`define LPM_STOP_REC_LONG 4096
`define LPM_STOP_REC_SHORT 32
`define LPM_REC_CNT_W 13

`endif

// [rtl/lpm_pkg.sv]
// Types shared by the low-power mode and clock gating block
package lpm_pkg;

  typedef enum logic [1:0] {
    LPM_RUN,
    LPM_WAIT,
    LPM_STOP,
    LPM_RECOVER
  } lpm_mode_e;

  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clock_double_rate_en;
    logic bus_clock_quad_rate_en;
    logic watchdog_en;
    logic irq_stack_ok;
  } lpm_clk_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lpm_apb_rsp_s;

  typedef struct packed {
    lpm_mode_e mode;
    logic [12:0] rec_cnt;
    logic [7:0] osc_sc;
    logic [7:0] cfg_one;
    logic break_stop_wait_flag;
    logic gate_sync1;
    logic gate_sync2;
    lpm_clk_s clk;
    lpm_apb_rsp_s rsp;
  } lpm_state_s;

endpackage

// [test/lpm_top_monitor.sv]
// Port assertions for the low-power block
`timescale 1ns/100ps
module lpm_chk
#(
  parameter logic [12:0] REC_LONG = 13'h1000,
  parameter logic [12:0] REC_SHORT = 13'h20
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic irq_req,
  input wire logic break_req,
  input wire logic emul_mode,
  input wire logic cpu_clk_en,
  input wire logic bus_clock_quad_rate_en,
  input wire logic irq_stack_ok
);
  logic quad;
  logic [12:0] rec_cnt_reg;
  logic [12:0] rec_cnt_next;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  assign quad = bus_clock_quad_rate_en;
  // Recovery is the only state with bus clocks on and stacking held
  assign rec_cnt_next = (quad && !cpu_clk_en && !irq_stack_ok) ?
    rec_cnt_reg + 13'h1 : 13'h0;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      rec_cnt_reg <= 13'h0;
    else
      rec_cnt_reg <= rec_cnt_next;
  // ========
  // Assertions
  a_wait_off:
    assert property (wait_instr && !stop_instr && cpu_clk_en |=>
      !cpu_clk_en && quad && irq_stack_ok) else $error("wait entry");
  a_stop_gate:
    assert property (stop_instr && cpu_clk_en |=>
      !quad && !cpu_clk_en && !irq_stack_ok) else $error("stop entry");
  a_stop_irq:
    assert property (!quad && irq_req |=> quad && !cpu_clk_en)
      else $error("irq stop exit");
  a_stop_brk:
    assert property (!quad && break_req |=> quad) else $error("brk exit");
  a_stack_hold:
    assert property ($rose(quad) |-> !irq_stack_ok [*4])
      else $error("early stacking");
  a_rec_count:
    assert property ($rose(irq_stack_ok) |->
      rec_cnt_reg == REC_SHORT || rec_cnt_reg == REC_LONG)
      else $error("recovery length");
  a_wait_irq:
    assert property (!cpu_clk_en && irq_stack_ok && irq_req |=> cpu_clk_en)
      else $error("irq wait exit");
  a_wait_brk:
    assert property (!cpu_clk_en && irq_stack_ok && break_req && emul_mode
      |=> cpu_clk_en) else $error("brk wait exit");
  c_wait: cover property (wait_instr && cpu_clk_en);
  c_stop: cover property (stop_instr && cpu_clk_en);
  c_rec: cover property ($rose(irq_stack_ok));
endmodule // lpm_chk

bind lpm_top lpm_chk #(.REC_LONG(REC_LONG), .REC_SHORT(REC_SHORT))
  lpm_chk_inst (.clk(clk), .arst_n(arst_n), .wait_instr(wait_instr),
  .stop_instr(stop_instr), .irq_req(irq_req), .break_req(break_req),
  .emul_mode(emul_mode), .cpu_clk_en(cpu_clk_en),
  .bus_clock_quad_rate_en(bus_clock_quad_rate_en),
  .irq_stack_ok(irq_stack_ok));

// [test/lpm_cpu_model.sv]
// Core stand-in issuing wait and stop instruction pulses
`timescale 1ns/100ps
module lpm_cpu_model
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cpu_clk_en,
  input wire logic do_wait,
  input wire logic do_stop,
  output logic wait_instr,
  output logic stop_instr
);
  // A gated core retires nothing
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      {wait_instr, stop_instr} <= 2'b00;
    else
      {wait_instr, stop_instr} <=
        {do_wait, do_stop} & {2{cpu_clk_en}};
endmodule // lpm_cpu_model

// [test/tb.sv]
// Self-checking bench for the low-power block
`timescale 1ns/100ps
module tb;
  localparam logic [12:0] RL = 13'h28;
  localparam logic [12:0] RS = 13'h4;
  logic clk, arst_n, psel, penable, pwrite, pready, err, irq, brk, emul;
  logic pin, dw, ds, wi, si, cpu, dbl, quad, wdog, stk, gon;
  logic [1:0] src, frq, rng;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fails, check_count, cycles;
  lpm_top #(.REC_LONG(RL), .REC_SHORT(RS)) lpm_top_inst (.clk(clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .pslverr(err), .prdata(prdata), .wait_instr(wi), .stop_instr(si),
    .irq_req(irq), .break_req(brk), .emul_mode(emul),
    .ext_clock_gate_pin(pin), .cpu_clk_en(cpu),
    .bus_clock_double_rate_en(dbl), .bus_clock_quad_rate_en(quad),
    .watchdog_en(wdog), .irq_stack_ok(stk), .osc_source_option(src),
    .internal_osc_freq_sel(frq), .external_crystal_range_sel(rng),
    .external_clock_gate_on(gon));
  lpm_cpu_model lpm_cpu_model_inst (.clk(clk), .arst_n(arst_n),
    .cpu_clk_en(cpu), .do_wait(dw), .do_stop(ds), .wait_instr(wi),
    .stop_instr(si));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (++cycles == 2000)
      report_and_stop();
  // ========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic instr(input logic stp);
    @(posedge clk);
    {ds, dw} <= {stp, ~stp};
    @(posedge clk);
    {ds, dw} <= 2'b00;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic kick(input logic b);
    @(posedge clk);
    {brk, irq} <= {b, ~b};
    @(posedge clk);
    {brk, irq} <= 2'b00;
    #1;
  endtask
  // ========
  // Scenarios
  task automatic t_osc();
    apb(0, 8'h00, 0);
    chk(rd, 32'h20);
    chk({src, frq, rng, gon}, 7'h10);
    for (int i = 0; i < 3; i++)
    begin
      pin <= 1'(i);
      apb(1, 8'h00, {24'h0, 2'(i), 2'(i), 2'(2 - i), 2'b10});
      apb(0, 8'h00, 0);
      chk(rd, {24'h0, 2'(i), 2'(i), 2'(2 - i), 1'b1, 1'(i)});
      chk({src, frq, rng, gon}, {2'(i), 2'(i), 2'(2 - i), 1'b1});
    end
    apb(1, 8'h04, 32'h4);
    apb(0, 8'h10, 0);
    chk({err, rd}, 33'h1_0000_0000);
    chk(wdog, 1'b0);
  endtask
  task automatic t_wait();
    apb(1, 8'h04, 32'h0);
    instr(1'b0);
    chk({cpu, quad, dbl, wdog}, 4'h7);
    apb(0, 8'h0C, 0);
    chk(rd, 32'h5);
    kick(1'b1);
    chk(cpu, 1'b0);
    apb(0, 8'h08, 0);
    chk(rd, 32'h2);
    apb(1, 8'h08, 32'h2);
    apb(0, 8'h08, 0);
    chk(rd, 32'h0);
    emul <= 1'b1;
    kick(1'b1);
    chk(cpu, 1'b1);
    emul <= 1'b0;
    instr(1'b0);
    kick(1'b0);
    chk(cpu, 1'b1);
  endtask
  task automatic t_stop(input logic [7:0] cfg, input logic b,
    input logic [12:0] n);
    int k;
    apb(1, 8'h04, {24'h0, cfg});
    instr(1'b1);
    chk({cpu, quad, stk, dbl}, {3'b000, cfg[1]});
    kick(b);
    chk({quad, cpu}, 2'b10);
    for (k = 0; stk !== 1'b1 && k < 5000; k++)
      @(posedge clk) #1;
    chk(k, n);
  endtask
  task automatic report_and_stop();
    if (cycles >= 2000)
      fails++;
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {arst_n, psel, penable, pwrite, irq, brk, emul, pin, dw, ds} = '0;
    {paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_osc();
    t_wait();
    t_stop(8'h00, 1'b0, RL);
    t_stop(8'h03, 1'b1, RS);
    report_and_stop();
  end
endmodule // tb
